// ==== shared/fmcu_defines.svh ====
// Constants for the float multiply and convert unit
`ifndef FMCU_DEFINES_SVH
`define FMCU_DEFINES_SVH

// ==========================================================
// Instruction encodings
`define FMCU_OP_SEL_SINGLE 16'hF001
`define FMCU_OP_SEL_DOUBLE 16'hF009
`define FMCU_OP_SEL_WORD 16'hF002
`define FMCU_OP_SEL_LONG 16'hF00A
`define FMCU_OP_MUL_HI 8'hF2
`define FMCU_OP_MODI_HI 8'hF3
`define FMCU_OP_CONV_HI 8'hFB
`define FMCU_OP_NEG_HI 10'h3C7
`define FMCU_OP_STAT_HI 10'h3C2

// ==========================================================
// Status word fields
`define FMCU_ST_RSV_HI 13
`define FMCU_ST_RSV_LO 12
`define FMCU_ST_UNDEF 11
`define FMCU_ST_UNF 10
`define FMCU_ST_OVF 9
`define FMCU_ST_CONV 8
`define FMCU_ST_DBL 7
`define FMCU_ST_LONG 6
`define FMCU_ST_CHOP 5
`define FMCU_ST_MAINT 4
`define FMCU_ST_N 3
`define FMCU_ST_Z 2
`define FMCU_ST_V 1
`define FMCU_ST_C 0
`define FMCU_ST_RESET 16'h0000

// ==========================================================
// Arithmetic constants
`define FMCU_SIG_SP 7'd24
`define FMCU_SIG_DP 7'd56
`define FMCU_PROD_SP 7'd48
`define FMCU_PROD_DP 7'd59
`define FMCU_EXP_BIAS 11'sd128
`define FMCU_EXP_TOP 11'sd255
`define FMCU_INT_MAXK 11'sd32
`define FMCU_LIM_WORD 33'h0_0000_8000
`define FMCU_LIM_LONG 33'h0_8000_0000
`define FMCU_ONES 64'hFFFF_FFFF_FFFF_FFFF
`define FMCU_MSB 64'h8000_0000_0000_0000

`endif

// ==== shared/fmcu_pkg.sv ====
// Types shared by the float multiply and convert unit
package fmcu_pkg;
  typedef struct packed {
    logic sign;
    logic [7:0] expo;
    logic [54:0] frac;
  } fmcu_float_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } fmcu_flags_t;

  typedef enum logic [3:0] {
    OP_IDLE, MULTIPLY_OP, MULTIPLY_INTEGERIZE_OP, NEGATE_OP,
    SELECT_SINGLE_OP, SELECT_DOUBLE_OP, SELECT_WORD_INTEGER_OP,
    SELECT_LONG_INTEGER_OP, STORE_CONVERT_INTEGER_OP, STORE_STATUS_OP
  } fmcu_op_t;

  typedef enum logic [2:0] {
    TRAP_NONE, TRAP_UNDEFINED, TRAP_OVERFLOW, TRAP_UNDERFLOW,
    TRAP_CONVERT
  } fmcu_trap_t;
endpackage

// ==== rtl/fmcu_mul.sv ====
// Mantissa multiplier with truncation to the generated product width
`include "fmcu_defines.svh"
module fmcu_mul
  import fmcu_pkg::*;
(
  input fmcu_float_t a_in,
  input fmcu_float_t b_in,
  input logic dbl_in,
  output logic [63:0] mant_out,
  output logic signed [10:0] expo_out,
  output logic sign_out,
  output logic zero_out
);
  logic [55:0] ma;
  logic [55:0] mb;
  logic [111:0] prod;
  logic [63:0] kept;
  logic [6:0] width;

  always_comb begin
    ma = {1'b1, a_in.frac};
    mb = {1'b1, b_in.frac};
    // Single operands carry 24 significant bits only
    if (!dbl_in) begin
      ma[31:0] = 32'h0;
      mb[31:0] = 32'h0;
    end
    prod = ma * mb;
    width = dbl_in ? `FMCU_PROD_DP : `FMCU_PROD_SP;
    kept = prod[111:48] & ~(`FMCU_ONES >> width);
    if (kept[63]) begin
      mant_out = kept;
      expo_out = $signed({3'b000, a_in.expo}) +
        $signed({3'b000, b_in.expo}) - `FMCU_EXP_BIAS;
    end else begin
      mant_out = kept << 1;
      expo_out = $signed({3'b000, a_in.expo}) +
        $signed({3'b000, b_in.expo}) - `FMCU_EXP_BIAS - 11'sd1;
    end
    sign_out = a_in.sign ^ b_in.sign;
    zero_out = (a_in.expo == 8'h00) || (b_in.expo == 8'h00);
  end
endmodule

// ==== rtl/fmcu_unit.sv ====
// Float multiply, integerize, negate, mode select and store unit
// ==========================================================
// Notes on behaviour
// - Even register: integer to pair, fraction here
// - Integer chop limit 24 single, 56 double
// - Overflow trapped: chopped integer, exponent wrapped
// - Overflow untrapped: both results exact zero
// - Huge product: chopped integer, zero fraction
// - Mid product: exact integer, rounded fraction
// - Below one: zero integer, rounded fraction
// - Underflow: trapped wraps exponent, else zeros
// - Integerize clears carry, flags from fraction
// - Negative zero source traps before multiply
// - Zero exponent gives zero, else truncated
// - Chop bit zero rounds, one chops
// - Multiply exceptions: zero or trapped wrapped
// - Multiply clears carry, flags from result
// - Negate flips sign or writes zero
// - Negate negative zero traps after executing
// - Decode single and double select opcodes
// - Decode word and long select opcodes
// - Conversion out of range: zero, carry
// - Conversion always chops
// - Long into register keeps upper word
// - Conversion fail traps; no negative zero trap
// - Stored status reads zeros in reserved bits
`include "fmcu_defines.svh"
module fmcu_unit
  import fmcu_pkg::*;
#(
  parameter bit MAINT_MODE = 1'b1
) (
  input logic SYS_CLK_IN,
  input logic RST_N_IN,
  input logic INSTR_VALID_IN,
  input logic [15:0] INSTR_IN,
  input fmcu_float_t ACC_IN,
  input fmcu_float_t SRC_IN,
  input logic DEST_IS_REG_IN,
  input logic STATUS_LOAD_IN,
  input logic [15:0] STATUS_DATA_IN,
  output fmcu_float_t RES_MAIN_OUT,
  output logic RES_MAIN_WE_OUT,
  output logic [1:0] RES_IDX_OUT,
  output fmcu_float_t RES_PAIR_OUT,
  output logic RES_PAIR_WE_OUT,
  output logic [1:0] RES_PAIR_IDX_OUT,
  output logic [31:0] INT_RESULT_OUT,
  output logic INT_WE_OUT,
  output logic INT_ONE_WORD_OUT,
  output fmcu_flags_t HOST_FLAGS_OUT,
  output logic HOST_FLAGS_WE_OUT,
  output logic TRAP_OUT,
  output fmcu_trap_t TRAP_CAUSE_OUT,
  output logic DONE_OUT,
  output logic [15:0] STATUS_OUT
);
  // ========================================================
  // Helpers
  function automatic logic [63:0] keep_top(input logic [63:0] m,
                                          input logic [6:0] n);
    keep_top = m & ~(`FMCU_ONES >> n);
  endfunction

  // Bit 64 of the answer flags a carry into the next exponent
  function automatic logic [64:0] round_m(input logic [63:0] m,
                                         input logic dbl,
                                         input logic chop);
    logic [6:0] sig;
    logic [64:0] sum;
    sig = dbl ? `FMCU_SIG_DP : `FMCU_SIG_SP;
    sum = {1'b0, m} + (chop ? 65'h0 : (65'h1 << (7'd63 - sig)));
    if (sum[64]) begin
      round_m = {1'b1, `FMCU_MSB};
    end else begin
      round_m = {1'b0, keep_top(sum[63:0], sig)};
    end
  endfunction

  function automatic fmcu_float_t pack(input logic s,
                                       input logic [7:0] e,
                                       input logic [63:0] m);
    pack = {s, e, m[62:8]};
  endfunction

  function automatic logic [6:0] lzc(input logic [63:0] m);
    lzc = 7'd64;
    for (int i = 0; i < 64; i++) begin
      if (m[i]) begin
        lzc = 7'(63 - i);
      end
    end
  endfunction

  function automatic fmcu_op_t decode(input logic [15:0] w);
    decode = OP_IDLE;
    if (w == `FMCU_OP_SEL_SINGLE) decode = SELECT_SINGLE_OP;
    if (w == `FMCU_OP_SEL_DOUBLE) decode = SELECT_DOUBLE_OP;
    if (w == `FMCU_OP_SEL_WORD) decode = SELECT_WORD_INTEGER_OP;
    if (w == `FMCU_OP_SEL_LONG) decode = SELECT_LONG_INTEGER_OP;
    if (w[15:8] == `FMCU_OP_MUL_HI) decode = MULTIPLY_OP;
    if (w[15:8] == `FMCU_OP_MODI_HI) decode = MULTIPLY_INTEGERIZE_OP;
    if (w[15:8] == `FMCU_OP_CONV_HI) decode = STORE_CONVERT_INTEGER_OP;
    if (w[15:6] == `FMCU_OP_NEG_HI) decode = NEGATE_OP;
    if (w[15:6] == `FMCU_OP_STAT_HI) decode = STORE_STATUS_OP;
  endfunction

  // ========================================================
  // State
  fmcu_float_t main_q, main_d, pair_q, pair_d;
  logic main_we_q, main_we_d, pair_we_q, pair_we_d;
  logic [1:0] idx_q, idx_d, pidx_q, pidx_d;
  logic [31:0] int_q, int_d;
  logic int_we_q, int_we_d, one_q, one_d;
  fmcu_flags_t hf_q, hf_d;
  logic hf_we_q, hf_we_d, trap_q, trap_d, done_q, done_d;
  fmcu_trap_t cause_q, cause_d;
  logic [15:0] status_q, status_d;

  fmcu_op_t op_now;
  logic dbl, lng, chop, src_nz, undef_trap;
  logic [6:0] sig;
  logic [63:0] pm, fr, gm, cm;
  logic signed [10:0] pe, pe_r, kk, ge, ck;
  logic ps, pz, cfail;
  logic [64:0] rnd, grnd;
  logic [6:0] lz;
  logic [32:0] mag, lim;
  logic [31:0] ival;
  fmcu_float_t prod_f, gfrac;

  fmcu_mul u_mul (
    .a_in(ACC_IN),
    .b_in(SRC_IN),
    .dbl_in(dbl),
    .mant_out(pm),
    .expo_out(pe),
    .sign_out(ps),
    .zero_out(pz)
  );

  // ========================================================
  // Datapath and next state
  always_comb begin
    // Modes are sampled from the status word as the op starts
    dbl = status_q[`FMCU_ST_DBL];
    lng = status_q[`FMCU_ST_LONG];
    chop = status_q[`FMCU_ST_CHOP];
    op_now = decode(INSTR_IN);
    sig = dbl ? `FMCU_SIG_DP : `FMCU_SIG_SP;
    src_nz = SRC_IN.sign && (SRC_IN.expo == 8'h00);
    undef_trap = status_q[`FMCU_ST_UNDEF] && src_nz;
    rnd = round_m(pm, dbl, chop);
    pe_r = pe + (rnd[64] ? 11'sd1 : 11'sd0);
    prod_f = pack(ps, pe_r[7:0], rnd[63:0]);
    kk = pe - `FMCU_EXP_BIAS;
    fr = pm << kk[5:0];
    lz = lzc(fr);
    gm = fr << lz[5:0];
    grnd = round_m(gm, dbl, chop);
    ge = `FMCU_EXP_BIAS - $signed({4'h0, lz}) +
      (grnd[64] ? 11'sd1 : 11'sd0);
    gfrac = (fr == 64'h0) ? '0 : pack(ps, ge[7:0], grnd[63:0]);
    // Truncation by shifting is the chop of the conversion
    ck = $signed({3'b000, ACC_IN.expo}) - `FMCU_EXP_BIAS;
    cm = keep_top({1'b1, ACC_IN.frac, 8'h00}, sig);
    mag = 33'h0;
    if (ck > 11'sd0 && ck <= `FMCU_INT_MAXK) begin
      mag = 33'(cm >> (7'd64 - 7'(ck)));
    end
    lim = lng ? `FMCU_LIM_LONG : `FMCU_LIM_WORD;
    cfail = (ck > `FMCU_INT_MAXK) ||
      (mag > (ACC_IN.sign ? lim : lim - 33'h1));
    ival = cfail ? 32'h0 :
      (ACC_IN.sign ? (~mag[31:0] + 32'h1) : mag[31:0]);

    main_d = '0;
    main_we_d = 1'b0;
    idx_d = INSTR_IN[7:6];
    pair_d = '0;
    pair_we_d = 1'b0;
    pidx_d = INSTR_IN[7:6] | 2'b01;
    int_d = 32'h0;
    int_we_d = 1'b0;
    one_d = 1'b0;
    hf_d = hf_q;
    hf_we_d = 1'b0;
    trap_d = 1'b0;
    cause_d = TRAP_NONE;
    done_d = 1'b0;
    status_d = status_q;

    if (INSTR_VALID_IN) begin
      case (op_now)
        MULTIPLY_OP: begin
          done_d = 1'b1;
          if (undef_trap) begin
            trap_d = 1'b1;
            cause_d = TRAP_UNDEFINED;
          end else begin
            main_we_d = 1'b1;
            status_d[`FMCU_ST_C] = 1'b0;
            status_d[`FMCU_ST_V] = !pz && (pe_r > `FMCU_EXP_TOP);
            if (pz) begin
              main_d = '0;
            end else if (pe_r > `FMCU_EXP_TOP) begin
              trap_d = status_q[`FMCU_ST_OVF];
              cause_d = TRAP_OVERFLOW;
              main_d = trap_d ? prod_f : '0;
            end else if (pe_r < 11'sd1) begin
              trap_d = status_q[`FMCU_ST_UNF];
              cause_d = TRAP_UNDERFLOW;
              main_d = trap_d ? prod_f : '0;
            end else begin
              main_d = prod_f;
            end
            if (!trap_d) cause_d = TRAP_NONE;
            status_d[`FMCU_ST_Z] = (main_d.expo == 8'h00);
            status_d[`FMCU_ST_N] = main_d.sign;
          end
        end
        MULTIPLY_INTEGERIZE_OP: begin
          done_d = 1'b1;
          if (undef_trap) begin
            trap_d = 1'b1;
            cause_d = TRAP_UNDEFINED;
          end else begin
            main_we_d = 1'b1;
            pair_we_d = !INSTR_IN[6];
            status_d[`FMCU_ST_C] = 1'b0;
            status_d[`FMCU_ST_V] = !pz && (pe > `FMCU_EXP_TOP);
            if (pz) begin
              main_d = '0;
            end else if (pe > `FMCU_EXP_TOP) begin
              trap_d = status_q[`FMCU_ST_OVF];
              cause_d = TRAP_OVERFLOW;
              pair_d = trap_d ? pack(ps, pe[7:0], keep_top(pm, sig))
                : '0;
            end else if (pe < 11'sd1) begin
              trap_d = status_q[`FMCU_ST_UNF];
              cause_d = TRAP_UNDERFLOW;
              main_d = trap_d ? prod_f : '0;
            end else if (kk <= 11'sd0) begin
              main_d = prod_f;
            end else if (kk >= $signed({4'h0, sig})) begin
              pair_d = pack(ps, pe[7:0], keep_top(pm, sig));
            end else begin
              pair_d = pack(ps, pe[7:0], keep_top(pm, 7'(kk)));
              main_d = gfrac;
            end
            if (!trap_d) cause_d = TRAP_NONE;
            status_d[`FMCU_ST_Z] = (main_d.expo == 8'h00);
            status_d[`FMCU_ST_N] = main_d.sign;
          end
        end
        NEGATE_OP: begin
          done_d = 1'b1;
          main_we_d = 1'b1;
          if (SRC_IN.expo != 8'h00) begin
            main_d = {~SRC_IN.sign, SRC_IN.expo, SRC_IN.frac};
          end
          status_d[`FMCU_ST_C] = 1'b0;
          status_d[`FMCU_ST_V] = 1'b0;
          status_d[`FMCU_ST_Z] = (SRC_IN.expo == 8'h00);
          status_d[`FMCU_ST_N] = main_d.sign;
          // Result is written in the same cycle as the trap
          trap_d = undef_trap;
          cause_d = undef_trap ? TRAP_UNDEFINED : TRAP_NONE;
        end
        SELECT_SINGLE_OP: begin
          done_d = 1'b1;
          status_d[`FMCU_ST_DBL] = 1'b0;
        end
        SELECT_DOUBLE_OP: begin
          done_d = 1'b1;
          status_d[`FMCU_ST_DBL] = 1'b1;
        end
        SELECT_WORD_INTEGER_OP: begin
          done_d = 1'b1;
          status_d[`FMCU_ST_LONG] = 1'b0;
        end
        SELECT_LONG_INTEGER_OP: begin
          done_d = 1'b1;
          status_d[`FMCU_ST_LONG] = 1'b1;
        end
        STORE_CONVERT_INTEGER_OP: begin
          done_d = 1'b1;
          int_we_d = 1'b1;
          one_d = !lng || DEST_IS_REG_IN;
          if (!lng) begin
            int_d = {16'h0000, ival[15:0]};
          end else if (DEST_IS_REG_IN) begin
            int_d = {16'h0000, ival[31:16]};
          end else begin
            int_d = ival;
          end
          status_d[`FMCU_ST_C] = cfail;
          status_d[`FMCU_ST_V] = 1'b0;
          status_d[`FMCU_ST_Z] = (ival == 32'h0);
          status_d[`FMCU_ST_N] = ival[31];
          hf_d = {ival[31], ival == 32'h0, 1'b0, cfail};
          hf_we_d = 1'b1;
          // The accumulator is not tested for negative zero here
          trap_d = cfail && status_q[`FMCU_ST_CONV];
          cause_d = trap_d ? TRAP_CONVERT : TRAP_NONE;
        end
        STORE_STATUS_OP: begin
          done_d = 1'b1;
          int_we_d = 1'b1;
          one_d = 1'b1;
          int_d = {16'h0000, status_q};
          int_d[`FMCU_ST_RSV_HI] = 1'b0;
          int_d[`FMCU_ST_RSV_LO] = 1'b0;
          if (!MAINT_MODE) int_d[`FMCU_ST_MAINT] = 1'b0;
        end
        default: begin
          done_d = 1'b0;
        end
      endcase
    end
    // A host status load overrides any update of the same cycle
    if (STATUS_LOAD_IN) status_d = STATUS_DATA_IN;
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      main_q <= '0;
      main_we_q <= 1'b0;
      idx_q <= 2'h0;
      pair_q <= '0;
      pair_we_q <= 1'b0;
      pidx_q <= 2'h1;
      int_q <= 32'h0;
      int_we_q <= 1'b0;
      one_q <= 1'b0;
      hf_q <= '0;
      hf_we_q <= 1'b0;
      trap_q <= 1'b0;
      cause_q <= TRAP_NONE;
      done_q <= 1'b0;
      status_q <= `FMCU_ST_RESET;
    end else begin
      main_q <= main_d;
      main_we_q <= main_we_d;
      idx_q <= idx_d;
      pair_q <= pair_d;
      pair_we_q <= pair_we_d;
      pidx_q <= pidx_d;
      int_q <= int_d;
      int_we_q <= int_we_d;
      one_q <= one_d;
      hf_q <= hf_d;
      hf_we_q <= hf_we_d;
      trap_q <= trap_d;
      cause_q <= cause_d;
      done_q <= done_d;
      status_q <= status_d;
    end
  end

  assign RES_MAIN_OUT = main_q;
  assign RES_MAIN_WE_OUT = main_we_q;
  assign RES_IDX_OUT = idx_q;
  assign RES_PAIR_OUT = pair_q;
  assign RES_PAIR_WE_OUT = pair_we_q;
  assign RES_PAIR_IDX_OUT = pidx_q;
  assign INT_RESULT_OUT = int_q;
  assign INT_WE_OUT = int_we_q;
  assign INT_ONE_WORD_OUT = one_q;
  assign HOST_FLAGS_OUT = hf_q;
  assign HOST_FLAGS_WE_OUT = hf_we_q;
  assign TRAP_OUT = trap_q;
  assign TRAP_CAUSE_OUT = cause_q;
  assign DONE_OUT = done_q;
  assign STATUS_OUT = status_q;

  // ========================================================
  // Checks
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  // Flags the op whose results stand on the outputs this cycle
  logic was_mul, was_mod;
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      was_mul <= 1'b0;
      was_mod <= 1'b0;
    end else begin
      was_mul <= INSTR_VALID_IN && op_now == MULTIPLY_OP;
      was_mod <= INSTR_VALID_IN && op_now == MULTIPLY_INTEGERIZE_OP;
    end
  end

  AST_ODD_NO_PAIR: assert property (
    INSTR_VALID_IN && op_now == MULTIPLY_INTEGERIZE_OP && INSTR_IN[6]
    |=> !RES_PAIR_WE_OUT) else $error("pair written for odd register");
  AST_SINGLE_CHOP: assert property (
    RES_PAIR_WE_OUT && !$past(status_q[`FMCU_ST_DBL])
    |-> RES_PAIR_OUT.frac[31:0] == 32'h0)
    else $error("single integer part not chopped to 24 bits");
  AST_MOD_OVF_ZERO: assert property (
    was_mod && TRAP_OUT && TRAP_CAUSE_OUT == TRAP_OVERFLOW
    |-> RES_MAIN_OUT == '0) else $error("fraction not zero on overflow");
  AST_MOD_OVF_QUIET: assert property (
    was_mod && status_q[`FMCU_ST_V] && !TRAP_OUT
    |-> RES_PAIR_OUT == '0 && RES_MAIN_OUT == '0)
    else $error("untrapped overflow left nonzero result");
  AST_MOD_CARRY: assert property (
    was_mod && RES_MAIN_WE_OUT |-> !status_q[`FMCU_ST_C] &&
    status_q[`FMCU_ST_Z] == (RES_MAIN_OUT.expo == 8'h00))
    else $error("integerize flags wrong");
  AST_UNDEF_BEFORE: assert property (
    TRAP_OUT && TRAP_CAUSE_OUT == TRAP_UNDEFINED && (was_mul || was_mod)
    |-> !RES_MAIN_WE_OUT && !RES_PAIR_WE_OUT)
    else $error("result written despite early trap");
  AST_MUL_QUIET: assert property (
    was_mul && status_q[`FMCU_ST_V] && !TRAP_OUT |-> RES_MAIN_OUT == '0)
    else $error("untrapped multiply overflow not zero");
  AST_NEG_SIGN: assert property (
    INSTR_VALID_IN && op_now == NEGATE_OP && SRC_IN.expo != 8'h00
    |=> RES_MAIN_OUT.sign != $past(SRC_IN.sign) && RES_MAIN_WE_OUT)
    else $error("negate did not flip sign");
  AST_DBL_SET: assert property (
    INSTR_VALID_IN && !STATUS_LOAD_IN && INSTR_IN == `FMCU_OP_SEL_DOUBLE
    |=> status_q[`FMCU_ST_DBL] && DONE_OUT)
    else $error("double select not set");
  AST_LONG_CLR: assert property (
    INSTR_VALID_IN && !STATUS_LOAD_IN && INSTR_IN == `FMCU_OP_SEL_WORD
    |=> !status_q[`FMCU_ST_LONG]) else $error("long select not cleared");
  AST_CONV_FAIL: assert property (
    INT_WE_OUT && HOST_FLAGS_WE_OUT && HOST_FLAGS_OUT.c
    |-> INT_RESULT_OUT == 32'h0) else $error("failed convert not zero");
  AST_STAT_RSV: assert property (
    INT_WE_OUT && !HOST_FLAGS_WE_OUT |-> INT_RESULT_OUT[13:12] == 2'b00)
    else $error("reserved status bits not zero");

  COV_MUL_OVF_TRAP: cover property (
    was_mul && TRAP_OUT && TRAP_CAUSE_OUT == TRAP_OVERFLOW);
  COV_MOD_PAIR: cover property (RES_PAIR_WE_OUT && RES_MAIN_WE_OUT);
  COV_CONV_FAIL: cover property (HOST_FLAGS_WE_OUT && HOST_FLAGS_OUT.c);
endmodule

// ==== verif/fmcu_host_model.sv ====
// Host core model that issues instructions and status loads
module fmcu_host_model
  import fmcu_pkg::*;
(
  input wire logic clk_in,
  output logic valid_out,
  output logic [15:0] instr_out,
  output fmcu_float_t acc_out,
  output fmcu_float_t src_out,
  output logic dreg_out,
  output logic ld_out,
  output logic [15:0] ld_data_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    valid_out = 1'b0;
    instr_out = 16'h0000;
    acc_out = '0;
    src_out = '0;
    dreg_out = 1'b0;
    ld_out = 1'b0;
    ld_data_out = 16'h0000;
  end

  // ==========================================================
  // Issue holds for one edge; back-to-back calls keep valid high
  task automatic issue(input logic [15:0] i, input fmcu_float_t a,
      input fmcu_float_t b, input logic r);
    #1;
    valid_out = 1'b1;
    instr_out = i;
    acc_out = a;
    src_out = b;
    dreg_out = r;
    @(posedge clk_in);
  endtask

  // Released operands flip so stale values can never pass for data
  task automatic idle();
    #1;
    valid_out = 1'b0;
    instr_out = ~instr_out;
    acc_out = ~acc_out;
    src_out = ~src_out;
    dreg_out = ~dreg_out;
    @(posedge clk_in);
  endtask

  task automatic load(input logic [15:0] v);
    #1;
    ld_out = 1'b1;
    ld_data_out = v;
    @(posedge clk_in);
    #1;
    ld_out = 1'b0;
    ld_data_out = ~v;
    @(posedge clk_in);
  endtask
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the float multiply and convert unit
module tb_top
  import fmcu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic mw;
    fmcu_float_t m;
    logic pw;
    fmcu_float_t p;
    logic iw;
    logic [15:0] iv;
    fmcu_trap_t tc;
    logic [3:0] fl;
  } fmcu_exp_t;

  localparam fmcu_float_t Z = '0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic valid, dreg, ld, mwe, pwe, iwe, one_w, hfwe, trp, done;
  logic [15:0] instr, ldd, st;
  logic [1:0] ridx, pidx;
  logic [31:0] ires;
  fmcu_float_t acc, src, rm, rp;
  fmcu_flags_t hf;
  fmcu_trap_t tc;
  fmcu_exp_t q[$];
  fmcu_exp_t e;
  logic [3:0] fl = 4'h0;
  logic s1, s2;
  int e1, e2, errors = 0, tests_run = 0, cyc = 0;
  logic [15:0] ops[4] = '{16'hF009, 16'hF00A, 16'hF001, 16'hF002};
  logic [1:0] modes[4] = '{2'h2, 2'h3, 2'h1, 2'h0};

  always #5 clk = ~clk;

  fmcu_host_model u_host (.clk_in(clk), .valid_out(valid),
    .instr_out(instr), .acc_out(acc), .src_out(src), .dreg_out(dreg),
    .ld_out(ld), .ld_data_out(ldd));

  fmcu_unit u_dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
    .INSTR_VALID_IN(valid), .INSTR_IN(instr), .ACC_IN(acc),
    .SRC_IN(src), .DEST_IS_REG_IN(dreg), .STATUS_LOAD_IN(ld),
    .STATUS_DATA_IN(ldd), .RES_MAIN_OUT(rm), .RES_MAIN_WE_OUT(mwe),
    .RES_IDX_OUT(ridx), .RES_PAIR_OUT(rp), .RES_PAIR_WE_OUT(pwe),
    .RES_PAIR_IDX_OUT(pidx), .INT_RESULT_OUT(ires), .INT_WE_OUT(iwe),
    .INT_ONE_WORD_OUT(one_w), .HOST_FLAGS_OUT(hf),
    .HOST_FLAGS_WE_OUT(hfwe), .TRAP_OUT(trp), .TRAP_CAUSE_OUT(tc),
    .DONE_OUT(done), .STATUS_OUT(st));

  // ==========================================================
  // Helpers
  function automatic fmcu_float_t f(logic s, int x, logic [54:0] fr);
    return {s, 8'(x), fr};
  endfunction

  function automatic void ex(logic mw, fmcu_float_t m, logic pw,
      fmcu_float_t p, logic iw, logic [15:0] iv, fmcu_trap_t t);
    q.push_back('{mw, m, pw, p, iw, iv, t, fl});
  endfunction

  task automatic check(string n, logic [63:0] seen, logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic run(logic [15:0] i, fmcu_float_t a, fmcu_float_t b);
    u_host.issue(i, a, b, 1'b0);
    u_host.idle();
  endtask

  task automatic ldst(logic [15:0] v);
    fl = v[3:0];
    u_host.load(v);
  endtask

  task automatic cv(fmcu_float_t a, logic [15:0] v, fmcu_trap_t t,
      logic [3:0] nf);
    fl = nf;
    ex(1'b0, Z, 1'b0, Z, 1'b1, v, t);
    run(16'hFB00, a, Z);
    check("host flags", 64'(hf), 64'(nf));
  endtask

  // ==========================================================
  // Every completion is compared with the queued expectation
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      test_done();
    end
    if (done === 1'b1) begin
      if (q.size() == 0) begin
        check("unexpected done", 64'h1, 64'h0);
      end else begin
        e = q.pop_front();
        check("main we", 64'(mwe), 64'(e.mw));
        if (e.mw) check("main", rm, e.m);
        check("pair we", 64'(pwe), 64'(e.pw));
        if (e.pw) check("pair", rp, e.p);
        check("int we", 64'(iwe), 64'(e.iw));
        if (e.iw) check("int", 64'(ires[15:0]), 64'(e.iv));
        check("trap", 64'(trp), 64'(e.tc != TRAP_NONE));
        if (e.tc != TRAP_NONE) check("cause", 64'(tc), 64'(e.tc));
        check("flags", 64'(st[3:0]), 64'(e.fl));
      end
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h0F58));
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    check("status after reset", 64'(st), 64'h0);
    @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      ex(1'b0, Z, 1'b0, Z, 1'b0, 16'h0000, TRAP_NONE);
      run(ops[k], Z, Z);
      check("mode bits", 64'(st[7:6]), 64'(modes[k]));
    end
    ldst(16'hFFFF);
    ex(1'b0, Z, 1'b0, Z, 1'b1, 16'hCFFF, TRAP_NONE);
    run(16'hF080, Z, Z);
    ldst(16'h0000);
    // Powers of two multiply exactly, so rounding mode cannot matter
    for (int k = 0; k < 8; k++) begin
      s1 = 1'($urandom_range(1));
      s2 = 1'($urandom_range(1));
      e1 = $urandom_range(150, 100);
      e2 = $urandom_range(150, 100);
      fl = {s1 ^ s2, 3'h0};
      ex(1'b1, f(s1 ^ s2, e1 + e2 - 129, '0), 1'b0, Z, 1'b0, 16'h0000,
        TRAP_NONE);
      u_host.issue(16'hF200, f(s1, e1, '0), f(s2, e2, '0), 1'b0);
    end
    u_host.idle();
    fl = 4'h4;
    ex(1'b1, Z, 1'b0, Z, 1'b0, 16'h0000, TRAP_NONE);
    run(16'hF200, f(0, 0, 55'h1), f(0, 140, '0));
    fl = 4'h6;
    ex(1'b1, Z, 1'b0, Z, 1'b0, 16'h0000, TRAP_NONE);
    run(16'hF200, f(1, 250, '0), f(0, 250, '0));
    fl = 4'h4;
    ex(1'b1, Z, 1'b0, Z, 1'b0, 16'h0000, TRAP_NONE);
    run(16'hF200, f(0, 1, '0), f(0, 1, '0));
    fl = 4'h6;
    ex(1'b1, Z, 1'b1, Z, 1'b0, 16'h0000, TRAP_NONE);
    run(16'hF300, f(0, 250, '0), f(0, 250, '0));
    fl = 4'h0;
    ex(1'b1, f(0, 128, '0), 1'b1, f(0, 129, '0), 1'b0, 16'h0000,
      TRAP_NONE);
    run(16'hF300, f(0, 129, '0), f(0, 129, 55'h40_0000_0000_0000));
    ex(1'b1, f(0, 128, '0), 1'b0, Z, 1'b0, 16'h0000, TRAP_NONE);
    run(16'hF340, f(0, 129, '0), f(0, 129, 55'h40_0000_0000_0000));
    ex(1'b1, f(0, 128, 55'h40_0000_0000_0000), 1'b1, Z, 1'b0, 16'h0000,
      TRAP_NONE);
    run(16'hF300, f(0, 128, '0), f(0, 129, 55'h40_0000_0000_0000));
    fl = 4'h4;
    ex(1'b1, Z, 1'b1, f(0, 171, '0), 1'b0, 16'h0000, TRAP_NONE);
    run(16'hF300, f(0, 150, '0), f(0, 150, '0));
    ex(1'b1, Z, 1'b1, Z, 1'b0, 16'h0000, TRAP_NONE);
    run(16'hF300, f(0, 1, '0), f(0, 1, '0));
    // A half-LSB tail rounds up, and chop drops it
    fl = 4'h0;
    ex(1'b1, f(0, 127, 55'h40_0002_0000_0000), 1'b0, Z, 1'b0, 16'h0000,
      TRAP_NONE);
    run(16'hF200, f(0, 128, 55'h40_0000_0000_0000),
      f(0, 128, 55'h1_0000_0000));
    ldst(16'h0020);
    ex(1'b1, f(0, 127, 55'h40_0001_0000_0000), 1'b0, Z, 1'b0, 16'h0000,
      TRAP_NONE);
    run(16'hF200, f(0, 128, 55'h40_0000_0000_0000),
      f(0, 128, 55'h1_0000_0000));
    ldst(16'h0200);
    fl = 4'hA;
    ex(1'b1, f(1, 115, '0), 1'b0, Z, 1'b0, 16'h0000, TRAP_OVERFLOW);
    run(16'hF200, f(1, 250, '0), f(0, 250, '0));
    fl = 4'h6;
    ex(1'b1, Z, 1'b1, f(0, 115, '0), 1'b0, 16'h0000, TRAP_OVERFLOW);
    run(16'hF300, f(0, 250, '0), f(0, 250, '0));
    ldst(16'h0400);
    ex(1'b1, f(0, 129, '0), 1'b0, Z, 1'b0, 16'h0000, TRAP_UNDERFLOW);
    run(16'hF200, f(0, 1, '0), f(0, 1, '0));
    ldst(16'h0800);
    ex(1'b0, Z, 1'b0, Z, 1'b0, 16'h0000, TRAP_UNDEFINED);
    run(16'hF200, f(0, 130, '0), f(1, 0, '0));
    fl = 4'h8;
    ex(1'b1, f(1, 130, '0), 1'b0, Z, 1'b0, 16'h0000, TRAP_NONE);
    run(16'hF1C0, Z, f(0, 130, '0));
    fl = 4'h4;
    ex(1'b1, Z, 1'b0, Z, 1'b0, 16'h0000, TRAP_UNDEFINED);
    run(16'hF1C0, Z, f(1, 0, '0));
    ex(1'b1, Z, 1'b0, Z, 1'b0, 16'h0000, TRAP_NONE);
    run(16'hF1C0, Z, f(0, 0, 55'h1));
    cv(f(1, 0, '0), 16'h0000, TRAP_NONE, 4'h4);
    ldst(16'h0100);
    cv(f(0, 130, 55'h70_0000_0000_0000), 16'h0003, TRAP_NONE, 4'h0);
    cv(f(1, 130, 55'h70_0000_0000_0000), 16'hFFFD, TRAP_NONE, 4'h8);
    cv(f(1, 144, '0), 16'h8000, TRAP_NONE, 4'h8);
    cv(f(0, 144, '0), 16'h0000, TRAP_CONVERT, 4'h5);
    ldst(16'h0140);
    fl = 4'h0;
    ex(1'b0, Z, 1'b0, Z, 1'b1, 16'h0001, TRAP_NONE);
    u_host.issue(16'hFB00, f(0, 145, '0), Z, 1'b1);
    u_host.idle();
    check("one word", 64'(one_w), 64'h1);
    repeat (3) @(posedge clk);
    check("pending results", 64'(q.size()), 64'h0);
    test_done();
  end
endmodule
